// File: core/bvs_blank_vseq.sv
// horizontal blanking, external gate masking and vertical phase sequencer
// assumes line/field sync and gate are asynchronous pins; rest same clock
`timescale 1ns/1ps
module bvs_blank_vseq
   import bvs_pkg::*;
#(
   parameter int REP_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // control register port
   input wire logic cfg_write,
   input wire logic cfg_read,
   input wire logic [bvs_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [bvs_pkg::DATA_W-1:0] cfg_wdata,
   output logic [bvs_pkg::DATA_W-1:0] cfg_rdata,
   // sensor-side pins
   input wire logic line_sync,
   input wire logic field_sync,
   input wire logic sync_gate_pin,
   // same-domain controls and sources
   input wire logic slave_mode,
   input wire logic shutter_pulse,
   input wire logic horiz_clock_in,
   input wire logic clamp_in,
   // horizontal settings
   input wire logic [bvs_pkg::POS_W-1:0] blank_pulse_position,
   input wire logic [bvs_pkg::EXT_W-1:0] extend_length,
   // vertical pattern settings
   input wire logic [bvs_pkg::NUM_PATTERNS*bvs_pkg::TOG_W-1:0] pattern_repeat_length,
   input wire logic [bvs_pkg::NUM_PATTERNS*bvs_pkg::NUM_PHASES-1:0] pattern_start_level,
   input wire logic [bvs_pkg::NUM_PATTERNS*bvs_pkg::NUM_PHASES*bvs_pkg::TOG_W-1:0]
      pattern_toggle_first,
   input wire logic [bvs_pkg::NUM_PATTERNS*bvs_pkg::NUM_PHASES*bvs_pkg::TOG_W-1:0]
      pattern_toggle_second,
   input wire logic [bvs_pkg::NUM_PATTERNS*REP_W-1:0] pattern_repeat_count,
   // region settings
   input wire logic [bvs_pkg::NUM_BOUNDS*bvs_pkg::LINE_W-1:0] region_boundary_line,
   input wire logic [bvs_pkg::NUM_REGIONS*bvs_pkg::PTR_W-1:0] region_sequence_pointer,
   input wire logic [bvs_pkg::NUM_SELECTS*bvs_pkg::SEL_W-1:0] pattern_select,
   // outputs
   output logic horiz_phase_a,
   output logic horiz_phase_b,
   output logic [bvs_pkg::NUM_PHASES-1:0] vertical_phase_clocks,
   output logic black_clamp_pulse,
   output logic line_counter_hold,
   output logic [bvs_pkg::REGION_W-1:0] region_index,
   output logic [bvs_pkg::LINE_W-1:0] line_count
);
   import bvs_pkg::*;

   // region number from line count; a zero boundary is unused so line 0 stays region 0
   function automatic logic [REGION_W-1:0] region_of(input logic [LINE_W-1:0] line,
         input logic [NUM_BOUNDS*LINE_W-1:0] bounds);
      logic [REGION_W-1:0] r;
      r = '0;
      for (int i = 0; i < NUM_BOUNDS; i++) begin
         if (bounds[i*LINE_W +: LINE_W] != '0 && line >= bounds[i*LINE_W +: LINE_W]) begin
            r = REGION_W'(i + 1);
         end
      end
      return r;
   endfunction

   // pin synchronisers: three stages, a change counts once stages two and three agree
   logic [NUM_PINS-1:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt, filt_r, filt_nxt;
   logic [NUM_PINS-1:0] prev_r, prev_nxt;
   logic line_fall, field_fall;

   always_comb begin
      s1_nxt = {sync_gate_pin, field_sync, line_sync};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      prev_nxt = filt_r;
      for (int i = 0; i < NUM_PINS; i++) begin
         filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         s3_r <= PIN_IDLE;
         filt_r <= PIN_IDLE;
         prev_r <= PIN_IDLE;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         filt_r <= filt_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign line_fall = prev_r[PIN_LINE] & ~filt_r[PIN_LINE];
   assign field_fall = prev_r[PIN_FIELD] & ~filt_r[PIN_FIELD];

   // control registers; readback is registered and holds until the next read
   logic h1_blank_level_r, h1_blank_level_nxt;
   logic gate_mask_select_r, gate_mask_select_nxt;
   logic blank_retime_r, blank_retime_nxt;
   logic blank_pulse_select_r, blank_pulse_select_nxt;
   logic blank_extend_r, blank_extend_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [REGION_W-1:0] region;

   always_comb begin
      h1_blank_level_nxt = h1_blank_level_r;
      gate_mask_select_nxt = gate_mask_select_r;
      blank_retime_nxt = blank_retime_r;
      blank_pulse_select_nxt = blank_pulse_select_r;
      blank_extend_nxt = blank_extend_r;
      rdata_nxt = rdata_r;
      if (cfg_write) begin
         if (cfg_addr == ADDR_CTRL_A) begin
            h1_blank_level_nxt = cfg_wdata[BIT_H1_LEVEL];
            gate_mask_select_nxt = cfg_wdata[BIT_GATE_SEL];
         end else if (cfg_addr == ADDR_CTRL_B) begin
            blank_retime_nxt = cfg_wdata[BIT_RETIME];
         end else if (cfg_addr == ADDR_CTRL_C) begin
            blank_pulse_select_nxt = cfg_wdata[BIT_PULSE_SEL];
            blank_extend_nxt = cfg_wdata[BIT_EXT_EN];
         end
      end
      if (cfg_read) begin
         rdata_nxt = '0;
         if (cfg_addr == ADDR_CTRL_A) begin
            rdata_nxt[BIT_H1_LEVEL] = h1_blank_level_r;
            rdata_nxt[BIT_GATE_SEL] = gate_mask_select_r;
         end else if (cfg_addr == ADDR_CTRL_B) begin
            rdata_nxt[BIT_RETIME] = blank_retime_r;
            rdata_nxt[BIT_REGION_LO +: REGION_W] = region;
         end else if (cfg_addr == ADDR_CTRL_C) begin
            rdata_nxt[BIT_PULSE_SEL] = blank_pulse_select_r;
            rdata_nxt[BIT_EXT_EN] = blank_extend_r;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         h1_blank_level_r <= CTRL_RESET;
         gate_mask_select_r <= CTRL_RESET;
         blank_retime_r <= CTRL_RESET;
         blank_pulse_select_r <= CTRL_RESET;
         blank_extend_r <= CTRL_RESET;
         rdata_r <= '0;
      end else begin
         h1_blank_level_r <= h1_blank_level_nxt;
         gate_mask_select_r <= gate_mask_select_nxt;
         blank_retime_r <= blank_retime_nxt;
         blank_pulse_select_r <= blank_pulse_select_nxt;
         blank_extend_r <= blank_extend_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign cfg_rdata = rdata_r;

   // horizontal blanking state
   logic [EXT_W-1:0] ext_cnt_r, ext_cnt_nxt;
   logic [POS_W-1:0] bp_cnt_r, bp_cnt_nxt;
   logic rt_a_r, rt_a_nxt, ha_r, ha_nxt;
   logic ext_running, blank_window, blank_pulse, a_now;

   assign ext_running = (ext_cnt_r != '0);
   // only the horizontal window waits for the extension
   // the line-fall cycle stays closed when an extension is about to load
   assign blank_window = ~filt_r[PIN_LINE] & ~ext_running &
      ~(line_fall & blank_extend_r & (extend_length != '0));
   // two pulses a fixed gap apart
   assign blank_pulse = blank_pulse_select_r & blank_window &
      (bp_cnt_r == blank_pulse_position || bp_cnt_r == blank_pulse_position + PULSE_GAP);
   // blank level, otherwise steady for the whole window
   assign a_now = blank_window ? (blank_pulse ? ~h1_blank_level_r : h1_blank_level_r)
                               : horiz_clock_in;

   // extension counter loads on line fall, then counts down
   always_comb begin
      ext_cnt_nxt = ext_cnt_r;
      if (line_fall && blank_extend_r) begin
         ext_cnt_nxt = extend_length;
      end else if (ext_running) begin
         ext_cnt_nxt = ext_cnt_r - EXT_W'(1);
      end
      // position counts from the start of the window, saturating
      bp_cnt_nxt = '0;
      if (blank_window) begin
         bp_cnt_nxt = (bp_cnt_r == '1) ? bp_cnt_r : bp_cnt_r + POS_W'(1);
      end
      // retiming costs one extra pixel clock of latency
      rt_a_nxt = a_now;
      ha_nxt = blank_retime_r ? rt_a_r : a_now;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ext_cnt_r <= '0;
         bp_cnt_r <= '0;
         rt_a_r <= CTRL_RESET;
         ha_r <= CTRL_RESET;
      end else begin
         ext_cnt_r <= ext_cnt_nxt;
         bp_cnt_r <= bp_cnt_nxt;
         rt_a_r <= rt_a_nxt;
         ha_r <= ha_nxt;
      end
   end

   assign horiz_phase_a = ha_r;
   assign horiz_phase_b = ~ha_r;
   // upstream line counters pause while this is high
   assign line_counter_hold = ext_running;

   // vertical patterns, one generator each
   logic [NUM_PHASES-1:0] pat_phases [NUM_PATTERNS];
   bvs_pattern_if #(.REP_W(REP_W)) pat_if [NUM_PATTERNS] ();

   for (genvar g = 0; g < NUM_PATTERNS; g++) begin : gen_pat
      assign pat_if[g].length = pattern_repeat_length[g*TOG_W +: TOG_W];
      assign pat_if[g].start = pattern_start_level[g*NUM_PHASES +: NUM_PHASES];
      assign pat_if[g].tog1 = pattern_toggle_first[g*NUM_PHASES*TOG_W +: NUM_PHASES*TOG_W];
      assign pat_if[g].tog2 = pattern_toggle_second[g*NUM_PHASES*TOG_W +: NUM_PHASES*TOG_W];
      assign pat_if[g].rep = pattern_repeat_count[g*REP_W +: REP_W];
      assign pat_if[g].restart = line_fall | field_fall;
      assign pat_phases[g] = pat_if[g].phases;
      bvs_pattern_gen #(.REP_W(REP_W)) u_gen (
         .clock(clock),
         .reset(reset),
         .pif(pat_if[g])
      );
   end

   // line count, gate latch and masked outputs
   logic [LINE_W-1:0] line_cnt_r, line_cnt_nxt;
   logic gate_latch_r, gate_latch_nxt;
   logic [NUM_PHASES-1:0] vout_r, vout_nxt;
   logic clamp_r, clamp_nxt;
   logic [PTR_W-1:0] seq_ptr;
   logic [SEL_W-1:0] pat_sel;
   logic gate_mask;

   assign region = region_of(line_cnt_r, region_boundary_line);
   assign seq_ptr = region_sequence_pointer[region*PTR_W +: PTR_W];
   assign pat_sel = (seq_ptr < PTR_W'(NUM_SELECTS)) ? pattern_select[seq_ptr*SEL_W +: SEL_W]
                                                   : '0;
   // only in slave mode, shutter gates select 1
   assign gate_mask = slave_mode & gate_latch_r & (~gate_mask_select_r | shutter_pulse);

   always_comb begin
      // field fall restarts at line zero
      line_cnt_nxt = line_cnt_r;
      if (field_fall) begin
         line_cnt_nxt = '0;
      end else if (line_fall && line_cnt_r != '1) begin
         line_cnt_nxt = line_cnt_r + LINE_W'(1);
      end
      gate_latch_nxt = line_fall ? filt_r[PIN_GATE] : gate_latch_r;
      vout_nxt = gate_mask ? '0 : pat_phases[pat_sel];
      clamp_nxt = gate_mask ? 1'b0 : clamp_in;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         line_cnt_r <= '0;
         gate_latch_r <= CTRL_RESET;
         vout_r <= '0;
         clamp_r <= CTRL_RESET;
      end else begin
         line_cnt_r <= line_cnt_nxt;
         gate_latch_r <= gate_latch_nxt;
         vout_r <= vout_nxt;
         clamp_r <= clamp_nxt;
      end
   end

   assign vertical_phase_clocks = vout_r;
   assign black_clamp_pulse = clamp_r;
   assign region_index = region;
   assign line_count = line_cnt_r;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_normal_blank_hold: assert property ((!blank_retime_r && blank_window && !blank_pulse_select_r)
      |=> horiz_phase_a == $past(h1_blank_level_r))
      else $error("normal blanking did not hold phase A level");
   a_sel_pulse_on: assert property ((!blank_retime_r && blank_pulse_select_r && blank_window
      && bp_cnt_r == blank_pulse_position) |=> horiz_phase_a != $past(h1_blank_level_r))
      else $error("selective pulse missing at programmed position");
   a_ext_delays_blank: assert property ((line_fall && blank_extend_r && extend_length != '0)
      |=> line_counter_hold && !blank_window)
      else $error("extension did not hold counters");
   a_phase_b_inverse: assert property (horiz_phase_b == !horiz_phase_a)
      else $error("phase B not opposite phase A");
   a_retime_latency: assert property (($past(blank_retime_r) && $past(blank_window, 2)
      && !$past(blank_pulse_select_r, 2)) |-> horiz_phase_a == $past(h1_blank_level_r, 2))
      else $error("retimed blanking level wrong");
   a_gate_masks_out: assert property (gate_mask
      |=> vertical_phase_clocks == '0 && !black_clamp_pulse)
      else $error("latched gate did not mask outputs");
   a_shutter_blocks: assert property ((gate_mask_select_r && !shutter_pulse)
      |=> black_clamp_pulse == $past(clamp_in))
      else $error("gate masked while shutter low");
   a_master_no_mask: assert property (!slave_mode |=> black_clamp_pulse == $past(clamp_in))
      else $error("gate masked outside slave mode");
   a_field_line_zero: assert property (field_fall |=> line_count == '0 && region_index == '0)
      else $error("field fall did not restart region zero");

   c_sel_pulse: cover property (blank_pulse_select_r && blank_pulse);
   c_ext_run: cover property (line_counter_hold ##1 !line_counter_hold);
   c_gate_mask: cover property (gate_mask && gate_mask_select_r);
   c_last_region: cover property (region_index == REGION_W'(NUM_BOUNDS));
endmodule // bvs_blank_vseq

// File: shared/bvs_pkg.sv
// constants for the horizontal blanking and vertical sequencer block
// assumes one pixel clock domain; pins arrive unsynchronised
// Operation
// - pulse select clear: blank while line sync low
// - pulse select set: two phase-A pulses
// - extension counter pauses line counters first
// - blank level bit sets phase-A level
// - phase B always opposite of phase A
// - retime bit re-registers phase-A blanking
// - 10-bit position places blanking pulses
// - extension delays horizontal, not vertical outputs
// - slave mode: gate pin masks vertical, clamp
// - select 0: gate latched at line fall
// - select 1: mask only while shutter high
// - four patterns, each drives four phases
// - up to five regions run in sequence
// - pattern repeats after programmed length
// - phase starts at level, toggles twice
// - repeat count; zero holds start level
// - region pointer picks pattern-select register
// - four 8-bit boundaries define regions
// - first boundary fixed at line zero
// - first region starts at field fall
// - toggle positions are 9-bit, 0-511
package bvs_pkg;
   // register port
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 8'h0A;
   localparam int BIT_H1_LEVEL = 0;
   localparam int BIT_GATE_SEL = 1;
   localparam int BIT_RETIME = 0;
   localparam int BIT_PULSE_SEL = 0;
   localparam int BIT_EXT_EN = 1;
   localparam int BIT_REGION_LO = 4;
   localparam logic CTRL_RESET = 1'b0;
   // pins: index of each synchronised input
   localparam int NUM_PINS = 3;
   localparam int PIN_LINE = 0;
   localparam int PIN_FIELD = 1;
   localparam int PIN_GATE = 2;
   localparam logic [NUM_PINS-1:0] PIN_IDLE = 3'h3;
   // horizontal blanking
   localparam int POS_W = 10;
   localparam int EXT_W = 9;
   localparam logic [POS_W-1:0] PULSE_GAP = 10'h002;
   // vertical sequencer
   localparam int NUM_PATTERNS = 4;
   localparam int NUM_PHASES = 4;
   localparam int NUM_REGIONS = 5;
   localparam int NUM_BOUNDS = 4;
   localparam int NUM_SELECTS = 5;
   localparam int TOG_W = 9;
   localparam int LINE_W = 8;
   localparam int PTR_W = 3;
   localparam int SEL_W = 2;
   localparam int REGION_W = 3;
   localparam logic [TOG_W-1:0] LEN_ONE = 9'h001;
endpackage

// File: shared/bvs_pattern_if.sv
// carries one vertical pattern's settings and its four phase levels
// assumes the sequencer drives settings and restart on the pixel clock
`timescale 1ns/1ps
interface bvs_pattern_if #(parameter int REP_W = 4);
   logic [bvs_pkg::TOG_W-1:0] length;
   logic [bvs_pkg::NUM_PHASES-1:0] start;
   logic [bvs_pkg::NUM_PHASES*bvs_pkg::TOG_W-1:0] tog1;
   logic [bvs_pkg::NUM_PHASES*bvs_pkg::TOG_W-1:0] tog2;
   logic [REP_W-1:0] rep;
   logic restart;
   logic [bvs_pkg::NUM_PHASES-1:0] phases;
   modport ctrl (output length, start, tog1, tog2, rep, restart, input phases);
   modport gen (input length, start, tog1, tog2, rep, restart, output phases);
endinterface

// File: core/bvs_pattern_gen.sv
// one vertical pattern: pixel counter, repeat counter, four phase levels
// assumes restart pulses once per line, on the pixel clock
`timescale 1ns/1ps
module bvs_pattern_gen
   import bvs_pkg::*;
#(
   parameter int REP_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // settings and phases
   bvs_pattern_if.gen pif
);
   logic [TOG_W-1:0] pos_r, pos_nxt;
   logic [REP_W-1:0] reps_r, reps_nxt;
   logic [NUM_PHASES-1:0] level_r, level_nxt;

   always_comb begin
      pos_nxt = pos_r;
      reps_nxt = reps_r;
      level_nxt = level_r;
      if (pif.restart) begin
         pos_nxt = '0;
         reps_nxt = '0;
         level_nxt = pif.start;
      end else if (reps_r < pif.rep) begin
         for (int i = 0; i < NUM_PHASES; i++) begin
            if (pos_r == pif.tog1[i*TOG_W +: TOG_W] || pos_r == pif.tog2[i*TOG_W +: TOG_W]) begin
               level_nxt[i] = ~level_r[i];
            end
         end
         if (pos_r >= pif.length - LEN_ONE || pif.length == '0) begin
            pos_nxt = '0;
            reps_nxt = reps_r + REP_W'(1);
            level_nxt = pif.start;
         end else begin
            pos_nxt = pos_r + LEN_ONE;
         end
      end else begin
         level_nxt = pif.start;
      end
   end

   // state registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pos_r <= '0;
         reps_r <= '0;
         level_r <= '0;
      end else begin
         pos_r <= pos_nxt;
         reps_r <= reps_nxt;
         level_r <= level_nxt;
      end
   end

   assign pif.phases = level_r;

   a_rep_zero_dc: assert property (@(posedge clock) disable iff (reset)
      ($past(pif.rep) == '0 && !$past(pif.restart)) |-> pif.phases == $past(pif.start))
      else $error("zero repeat count did not hold start level");
   a_pos_wraps: assert property (@(posedge clock) disable iff (reset)
      (!pif.restart && reps_r < pif.rep && pif.length != '0 && pos_r == pif.length - LEN_ONE)
      |=> pos_r == '0)
      else $error("pattern counter did not wrap at length");
endmodule // bvs_pattern_gen

// File: verification/bvs_sensor_model.sv
// sensor-side partner: drives the line sync, field sync and gate pins
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps
module bvs_sensor_model (
   // pixel clock
   clock,
   // pins toward the block
   line_sync,
   field_sync,
   sync_gate_pin
);
   input wire logic clock;
   output logic line_sync;
   output logic field_sync;
   output logic sync_gate_pin;
   // syncs idle high; gate starts low so nothing is masked
   initial begin
      line_sync = 1'b1;
      field_sync = 1'b1;
      sync_gate_pin = 1'b0;
   end
   task automatic line_pulse(input int low, input int high);
      line_sync = 1'b0;
      repeat (low) @(negedge clock);
      line_sync = 1'b1;
      repeat (high) @(negedge clock);
   endtask
   task automatic field_pulse();
      field_sync = 1'b0;
      repeat (6) @(negedge clock);
      field_sync = 1'b1;
      repeat (6) @(negedge clock);
   endtask
   task automatic set_gate(input logic v);
      sync_gate_pin = v;
   endtask
endmodule // bvs_sensor_model

// File: verification/bvs_blank_vseq_test.sv
// self-checking bench for the blanking and vertical sequencer block
// assumes the partner model owns the sync and gate pins
`timescale 1ns/1ps
module bvs_blank_vseq_test;
   import bvs_pkg::*;
   localparam int LIMIT = 20000;
   localparam logic [7:0] ADDRS [4] = '{8'h01, 8'h03, 8'h0A, 8'h55};
   localparam logic [7:0] FULL [4] = '{8'h03, 8'h01, 8'h03, 8'h00};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic cfg_write = 1'b0;
   logic cfg_read = 1'b0;
   logic [ADDR_W-1:0] cfg_addr = 8'h00;
   logic [DATA_W-1:0] cfg_wdata = 8'h00;
   logic slave_mode = 1'b0;
   logic shutter_pulse = 1'b0;
   logic horiz_clock_in = 1'b0;
   logic clamp_in = 1'b1;
   logic [POS_W-1:0] pos = 10'h000;
   logic [EXT_W-1:0] ext_len = 9'h000;
   logic [NUM_PATTERNS*TOG_W-1:0] rlen = {4{9'h020}};
   logic [15:0] slev = 16'h0000;
   logic [NUM_PATTERNS*NUM_PHASES*TOG_W-1:0] tog1 = '0;
   logic [NUM_PATTERNS*NUM_PHASES*TOG_W-1:0] tog2 = '0;
   logic [15:0] rcnt = 16'h1111;
   logic [31:0] bounds = 32'h08060402;
   logic [14:0] ptrs = 15'h0000;
   logic [9:0] sels = 10'h000;
   logic [DATA_W-1:0] cfg_rdata;
   logic line_sync, field_sync, sync_gate_pin, ha, hb, clamp, hold;
   logic [NUM_PHASES-1:0] vph;
   logic [REGION_W-1:0] region;
   logic [LINE_W-1:0] lcount;
   logic [1:0] mid;
   logic [31:0] seed = 32'h1961;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;

   bvs_sensor_model i_bvs_sensor_model (.clock(clock), .line_sync(line_sync),
      .field_sync(field_sync), .sync_gate_pin(sync_gate_pin));

   bvs_blank_vseq i_bvs_blank_vseq (.clock(clock), .reset(reset), .cfg_write(cfg_write),
      .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .line_sync(line_sync), .field_sync(field_sync), .sync_gate_pin(sync_gate_pin),
      .slave_mode(slave_mode), .shutter_pulse(shutter_pulse),
      .horiz_clock_in(horiz_clock_in), .clamp_in(clamp_in),
      .blank_pulse_position(pos), .extend_length(ext_len), .pattern_repeat_length(rlen),
      .pattern_start_level(slev), .pattern_toggle_first(tog1), .pattern_toggle_second(tog2),
      .pattern_repeat_count(rcnt), .region_boundary_line(bounds),
      .region_sequence_pointer(ptrs), .pattern_select(sels), .horiz_phase_a(ha),
      .horiz_phase_b(hb), .vertical_phase_clocks(vph), .black_clamp_pulse(clamp),
      .line_counter_hold(hold), .region_index(region), .line_count(lcount));

   // 4 ns pixel clock
   always #2 clock = ~clock;

   // xorshift keeps every run repeatable
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic mask_exp(input logic sl, input logic sel, input logic sh,
      input logic gt);
      return sl & gt & (~sel | sh);
   endfunction
   function automatic int width_exp(input int t1, input int t2, input int rep);
      return (rep == 0) ? 0 : t2 - t1;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // strobes are held over one rising edge, then dropped
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
      @(negedge clock);
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
      cfg_addr = a;
      cfg_read = 1'b1;
      @(negedge clock);
      cfg_read = 1'b0;
      @(negedge clock);
      d = cfg_rdata;
   endtask
   // one line; first is the sample index where phase A leaves the blank level
   task automatic blank_run(input logic lvl, input logic psel, input logic rt,
      output int first, output int n);
      cfg_wr(ADDR_CTRL_A, {7'h00, lvl});
      cfg_wr(ADDR_CTRL_B, {7'h00, rt});
      cfg_wr(ADDR_CTRL_C, {7'h00, psel});
      horiz_clock_in = psel ? lvl : ~lvl;
      first = -1;
      n = 0;
      fork
         i_bvs_sensor_model.line_pulse(40, 20);
         for (int k = 0; k < 60; k++) begin
            @(negedge clock);
            if (k == 30) mid = {ha, hb};
            if (ha !== lvl) begin
               n++;
               if (first < 0) first = k;
            end
         end
      join
   endtask

   // hang guard, far beyond the roughly 1440 cycles needed
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      int f0, f1, n, k;
      int cnt [4];
      logic lvl, mk;
      logic [7:0] rd;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      // reset values, writable bits and an unmapped address
      for (int i = 0; i < 4; i++) begin
         cfg_rd(ADDRS[i], rd);
         check("reg reset", rd, 8'h00);
         cfg_wr(ADDRS[i], 8'hFF);
         cfg_rd(ADDRS[i], rd);
         check("reg full", rd, FULL[i]);
         cfg_wr(ADDRS[i], 8'h00);
      end
      // both blank levels, plain and selective, selective also with retime
      for (int i = 0; i < 2; i++) begin
         lvl = i[0];
         pos = POS_W'(rnd() % 20);
         blank_run(lvl, 1'b0, 1'b0, f0, n);
         check("normal blank", mid, {lvl, ~lvl});
         pos = 10'h000;
         blank_run(lvl, 1'b1, 1'b0, f0, n);
         check("selective count", n, 2);
         check("selective blank", mid, {lvl, ~lvl});
         pos = POS_W'(1 + rnd() % 9);
         blank_run(lvl, 1'b1, 1'b0, f1, n);
         check("pulse offset", f1 - f0, pos);
         blank_run(lvl, 1'b1, 1'b1, f1, n);
         check("retimed offset", f1 - f0, pos + 1);
      end
      // extension holds the line counters for exactly its length
      cfg_wr(ADDR_CTRL_B, 8'h00);
      ext_len = EXT_W'(1 + rnd() % 20);
      cfg_wr(ADDR_CTRL_C, 8'h02);
      n = 0;
      fork
         i_bvs_sensor_model.line_pulse(40, 20);
         repeat (60) begin
            @(negedge clock);
            if (hold === 1'b1) n++;
         end
      join
      check("hold cycles", n, ext_len);
      cfg_wr(ADDR_CTRL_C, 8'h00);
      // each pattern picked through a random pointer; pattern 2 has zero repeats
      for (int g = 0; g < 4; g++) begin
         k = rnd() % 5;
         ptrs = {5{PTR_W'(k)}};
         sels = {5{~SEL_W'(g)}};
         sels[k*SEL_W +: SEL_W] = SEL_W'(g);
         for (int i = 0; i < 16; i++) begin
            tog1[i*TOG_W +: TOG_W] = TOG_W'(1 + rnd() % 10);
            tog2[i*TOG_W +: TOG_W] = TOG_W'(12 + rnd() % 10);
         end
         slev = 16'(rnd());
         rcnt = 16'h1111;
         rcnt[g*4 +: 4] = (g == 2) ? 4'h0 : 4'h1;
         // new start levels need two edges to reach the outputs before counting
         repeat (2) @(negedge clock);
         cnt = '{0, 0, 0, 0};
         fork
            i_bvs_sensor_model.line_pulse(40, 20);
            repeat (60) begin
               @(negedge clock);
               for (int i = 0; i < 4; i++) if (vph[i] !== slev[g*4+i]) cnt[i]++;
            end
         join
         for (int i = 0; i < 4; i++) begin
            check("phase width", cnt[i], width_exp(tog1[(g*4+i)*TOG_W +: TOG_W],
               tog2[(g*4+i)*TOG_W +: TOG_W], rcnt[g*4 +: 4]));
         end
      end
      // all mode, select, shutter and gate combinations on a steady pattern
      ptrs = 15'h0000;
      sels = 10'h000;
      rcnt = 16'h0000;
      slev = 16'hFFFF;
      for (int m = 0; m < 16; m++) begin
         slave_mode = m[0];
         shutter_pulse = m[2];
         i_bvs_sensor_model.set_gate(m[3]);
         cfg_wr(ADDR_CTRL_A, {6'h00, m[1], 1'b0});
         i_bvs_sensor_model.line_pulse(10, 10);
         mk = mask_exp(m[0], m[1], m[2], m[3]);
         check("vertical mask", vph, mk ? 4'h0 : 4'hF);
         check("clamp mask", clamp, !mk);
      end
      // regions follow the boundaries from the field start
      slave_mode = 1'b0;
      i_bvs_sensor_model.field_pulse();
      check("region at field start", region, 0);
      repeat (3) i_bvs_sensor_model.line_pulse(10, 10);
      check("region after 3 lines", region, 1);
      repeat (7) i_bvs_sensor_model.line_pulse(10, 10);
      check("region after 10 lines", region, 4);
      check("line count", lcount, 8'h0A);
      end_sim();
   end

endmodule // bvs_blank_vseq_test
